// ===== rtl/swr_defines.svh
`ifndef SWR_DEFINES_SVH
`define SWR_DEFINES_SVH

// timebase
`define SWR_CLK_KHZ 10000

// reset hold time after the last reset cause goes away
`define SWR_HOLD_TIME_MS 180
`define SWR_HOLD_CYCLES ((`SWR_HOLD_TIME_MS * `SWR_CLK_KHZ))

// watchdog timeout without a kick transition
`define SWR_WDT_TIMEOUT_MS 1400
`define SWR_WDT_CYCLES ((`SWR_WDT_TIMEOUT_MS * `SWR_CLK_KHZ))

// counter width, covers both terminal counts
`define SWR_CNT_W 24

// reset values
`define SWR_SYNC_RESET_LOW 1'h0
`define SWR_SYNC_RESET_HIGH 1'h1

// bit positions of the pin bundle
`define SWR_IN_UNDERVOLT 0
`define SWR_IN_MANUAL_N 1
`define SWR_IN_KICK 2
`define SWR_IN_W 3

`endif

// ===== rtl/swr_pkg.sv
`default_nettype none
`include "swr_defines.svh"

package swr_pkg;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_HOLD,
        ST_RUN
    } swr_state_t;

    // synchronised pin bundle
    typedef struct packed {
        logic kick;
        logic manualResetN;
        logic underVoltage;
    } swr_pins_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } swr_sync_regs_t;

    typedef struct packed {
        swr_state_t st;
        logic [`SWR_CNT_W-1:0] holdCnt;
        logic [`SWR_CNT_W-1:0] wdtCnt;
        logic kickPrev;
        logic resetN;
        logic resetHigh;
        logic pullupEn;
    } swr_regs_t;

endpackage : swr_pkg

`default_nettype wire

// ===== rtl/swr_sync.sv
`timescale 1ns/1ps
`default_nettype none

module swr_sync #(
    parameter logic INIT = 1'h0
) (
    input wire logic sys_clk, // timebase
    input wire logic reset_n, // async reset, active low
    input wire logic d, // asynchronous pin level
    output logic q // filtered synchronised level
);

    swr_pkg::swr_sync_regs_t r;
    swr_pkg::swr_sync_regs_t next_r;

    ////////////////////////////////////////////////////////////////////////
    // s1 feeds only s2; a change is taken once s2 and s3 agree
    always_comb begin
        next_r = r;
        next_r.s1 = d;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        if (r.s2 == r.s3) begin
            next_r.q = r.s3;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= {INIT, INIT, INIT, INIT};
        end else begin
            r <= next_r;
        end
    end

    assign q = r.q;

endmodule : swr_sync

`default_nettype wire

// ===== rtl/swr_supply_watchdog_reset.sv
`timescale 1ns/1ps
`default_nettype none
`include "swr_defines.svh"

// Summary of operation
// R1: below the trip threshold drive resetN low and resetHigh high.
// R2: after supply recovers keep resets asserted a further 180 ms.
// R3: any rising or falling kick edge restarts the watchdog timer.
// R4: 1.4 s without a kick edge starts a 180 ms reset cycle.
// R5: reset clears the watchdog; reset release restarts timeout from zero.
// R6: kick edges are ignored while a reset cycle runs.
// R7: at power-up reset held low; hold delay starts at upper threshold.
// R8: manual reset low asserts resets, held until 180 ms after release.
// R9: manual reset input has a pull-up so open reads inactive.
// R10: processor must toggle kick input faster than every 1.4 s.
// R11: each new supply dip restarts the hold timer.
// R12: undervoltage and manual reset synchronised before use.
// R13: hold and timeout are tick counters with parameter terminal counts.
module swr_supply_watchdog_reset #(
    parameter int unsigned HOLD_CYCLES = `SWR_HOLD_CYCLES,
    parameter int unsigned WDT_CYCLES = `SWR_WDT_CYCLES
) (
    input wire logic sys_clk, // 10 MHz timebase
    input wire logic reset_n, // async reset, active low
    input wire logic underVoltage, // comparator: supply below trip_threshold
    input wire logic manualResetInputN, // manual_reset_input, active low
    input wire logic watchdogKickInput, // processor_flag_output toggles
    output logic manualResetPullupEn, // keeps the internal pull-up on
    output logic resetN, // to processor_reset_input, active low
    output logic resetHigh // complementary reset, active high
);

    localparam logic [`SWR_CNT_W-1:0] HOLD_LAST =
        `SWR_CNT_W'(HOLD_CYCLES - 1);
    localparam logic [`SWR_CNT_W-1:0] WDT_LAST =
        `SWR_CNT_W'(WDT_CYCLES - 1);
    localparam logic [`SWR_IN_W-1:0] SYNC_INIT = {
        `SWR_SYNC_RESET_LOW,
        `SWR_SYNC_RESET_HIGH,
        `SWR_SYNC_RESET_LOW
    };

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [`SWR_IN_W-1:0] rawPins;
    logic [`SWR_IN_W-1:0] syncPins;
    swr_pkg::swr_pins_t pins;

    assign rawPins[`SWR_IN_UNDERVOLT] = underVoltage;
    assign rawPins[`SWR_IN_MANUAL_N] = manualResetInputN;
    assign rawPins[`SWR_IN_KICK] = watchdogKickInput;

    // manual reset idles high, matching its pull-up
    genvar gi;
    generate
        for (gi = 0; gi < `SWR_IN_W; gi++) begin : g_sync
            swr_sync #(
                .INIT(SYNC_INIT[gi])
            ) u_sync (
                .sys_clk(sys_clk),
                .reset_n(reset_n),
                .d(rawPins[gi]),
                .q(syncPins[gi])
            ); // see R12
        end
    endgenerate

    assign pins = swr_pkg::swr_pins_t'(syncPins);

    ////////////////////////////////////////////////////////////////////////
    // reset and watchdog sequencer
    swr_pkg::swr_regs_t r;
    swr_pkg::swr_regs_t next_r;
    logic cause;
    logic kickEdge;

    assign cause = pins.underVoltage | ~pins.manualResetN; // see R8
    assign kickEdge = pins.kick ^ r.kickPrev; // see R3

    always_comb begin
        next_r = r;
        next_r.kickPrev = pins.kick;
        next_r.pullupEn = 1'h1; // see R9
        unique case (r.st)
            swr_pkg::ST_RESET: begin
                next_r.holdCnt = '0;
                next_r.wdtCnt = '0; // see R5
                // hold delay starts only once the cause has gone
                if (!cause) begin
                    next_r.st = swr_pkg::ST_HOLD; // see R7
                end
            end
            swr_pkg::ST_HOLD: begin
                next_r.wdtCnt = '0; // see R6
                if (cause) begin
                    next_r.st = swr_pkg::ST_RESET; // see R11
                    next_r.holdCnt = '0;
                end else if (r.holdCnt == HOLD_LAST) begin
                    next_r.st = swr_pkg::ST_RUN; // see R2
                    next_r.holdCnt = '0;
                end else begin
                    next_r.holdCnt = r.holdCnt + `SWR_CNT_W'(1); // see R13
                end
            end
            swr_pkg::ST_RUN: begin
                if (cause) begin
                    next_r.st = swr_pkg::ST_RESET; // see R1
                    next_r.wdtCnt = '0;
                end else if (kickEdge) begin
                    next_r.wdtCnt = '0; // see R3
                end else if (r.wdtCnt == WDT_LAST) begin
                    next_r.st = swr_pkg::ST_HOLD; // see R4
                    next_r.wdtCnt = '0;
                end else begin
                    next_r.wdtCnt = r.wdtCnt + `SWR_CNT_W'(1); // see R13
                end
            end
            default: begin
                next_r.st = swr_pkg::ST_RESET;
            end
        endcase
        // outputs follow the next state so they come from flops
        next_r.resetN = (next_r.st == swr_pkg::ST_RUN); // see R1
        next_r.resetHigh = (next_r.st != swr_pkg::ST_RUN); // see R1
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            r.st <= swr_pkg::ST_RESET; // see R7
            r.holdCnt <= '0;
            r.wdtCnt <= '0;
            r.kickPrev <= 1'h0;
            r.resetN <= 1'h0;
            r.resetHigh <= 1'h1;
            r.pullupEn <= 1'h1;
        end else begin
            r <= next_r;
        end
    end

    assign resetN = r.resetN;
    assign resetHigh = r.resetHigh;
    assign manualResetPullupEn = r.pullupEn;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    sequence seqHoldDone;
        r.st == swr_pkg::ST_HOLD && !cause && r.holdCnt == HOLD_LAST;
    endsequence

    sequence seqWdtExpire;
        r.st == swr_pkg::ST_RUN && !cause && !kickEdge &&
            r.wdtCnt == WDT_LAST;
    endsequence

    sequence seqRelease;
        !resetN ##1 resetN;
    endsequence

    AST_UV_ASSERTS: assert property ( // see R1
        pins.underVoltage |=> !resetN && resetHigh)
        else $error("undervoltage did not assert reset");

    AST_COMPLEMENT: assert property ( // see R1
        resetN != resetHigh)
        else $error("reset outputs not complementary");

    AST_HOLD_END: assert property ( // see R2
        seqHoldDone |=> resetN && r.st == swr_pkg::ST_RUN)
        else $error("reset not released after hold delay");

    AST_HOLD_FULL: assert property ( // see R2
        seqRelease |-> $past(r.holdCnt, 1) == HOLD_LAST)
        else $error("reset released before hold count ended");

    AST_KICK_RESTART: assert property ( // see R3
        r.st == swr_pkg::ST_RUN && !cause && kickEdge |=> r.wdtCnt == '0)
        else $error("kick edge did not restart watchdog");

    AST_TIMEOUT: assert property ( // see R4
        seqWdtExpire |=> !resetN ##0 r.st == swr_pkg::ST_HOLD
            ##0 r.holdCnt == '0)
        else $error("watchdog expiry did not start reset cycle");

    AST_WDT_ZERO_AT_RELEASE: assert property ( // see R5
        seqRelease |-> r.wdtCnt == '0 ##1 r.wdtCnt <= `SWR_CNT_W'(1))
        else $error("watchdog not restarted at reset release");

    AST_KICK_IGNORED: assert property ( // see R6
        r.st != swr_pkg::ST_RUN |=> r.wdtCnt == '0)
        else $error("watchdog moved during reset cycle");

    AST_POWERUP_HOLD: assert property ( // see R7
        r.st == swr_pkg::ST_RESET && cause |=> r.st == swr_pkg::ST_RESET
            && !resetN)
        else $error("reset left before supply recovered");

    AST_MANUAL: assert property ( // see R8
        !pins.manualResetN |=> !resetN [*2])
        else $error("manual reset did not hold reset");

    AST_DIP_RESTART: assert property ( // see R11
        r.st == swr_pkg::ST_HOLD && cause |=> r.st == swr_pkg::ST_RESET
            && r.holdCnt == '0)
        else $error("supply dip did not restart hold timer");

    AST_MANUAL_HELD: assert property ( // see R8
        r.st == swr_pkg::ST_RESET && !pins.manualResetN |=>
            r.st == swr_pkg::ST_RESET && !resetN)
        else $error("manual reset released while still low");

    // counters must step by one, or the delays drift from their targets
    AST_HOLD_STEP: assert property ( // see R13
        r.st == swr_pkg::ST_HOLD && !cause && r.holdCnt != HOLD_LAST |=>
            r.holdCnt == $past(r.holdCnt) + `SWR_CNT_W'(1))
        else $error("hold counter did not advance by one");

    AST_WDT_STEP: assert property ( // see R13
        r.st == swr_pkg::ST_RUN && !cause && !kickEdge &&
            r.wdtCnt != WDT_LAST |=>
            r.wdtCnt == $past(r.wdtCnt) + `SWR_CNT_W'(1))
        else $error("watchdog counter did not advance by one");

    AST_PULLUP_ON: assert property ( // see R9
        manualResetPullupEn)
        else $error("manual reset pull-up switched off");

endmodule : swr_supply_watchdog_reset

`default_nettype wire

// ===== verification/swr_proc_model.sv
`timescale 1ns/1ps
`default_nettype none

module swr_proc_model (
    input wire logic sys_clk, // timebase
    input wire logic resetN, // reset from supervisor
    input wire logic kickEn, // software alive and kicking
    input wire logic rogue, // toggle even while held in reset
    input wire logic [7:0] period, // cycles between toggles
    output logic kick // drives the kick input
);
    logic [7:0] gap;
    initial begin
        kick = 1'h0;
        gap = 8'h00;
    end
    // a processor in reset cannot toggle; rogue breaks that on purpose
    always @(posedge sys_clk) begin
        if ((kickEn && resetN) || (rogue && !resetN)) begin
            gap <= (gap + 8'h01 >= period) ? 8'h00 : gap + 8'h01;
            if (gap + 8'h01 >= period) kick <= ~kick;
        end else begin
            gap <= 8'h00;
        end
    end
endmodule : swr_proc_model

`default_nettype wire

// ===== verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam int HOLD = 20;
    localparam int WDT = 50;
    logic sys_clk, reset_n, underVoltage, manualResetInputN;
    logic kickEn, rogue, kick, pullupEn, resetN, resetHigh;
    logic [7:0] period;
    int numErrors, checksDone, cycles;

    swr_supply_watchdog_reset #(.HOLD_CYCLES(HOLD), .WDT_CYCLES(WDT)) dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .underVoltage(underVoltage),
        .manualResetInputN(manualResetInputN), .watchdogKickInput(kick),
        .manualResetPullupEn(pullupEn), .resetN(resetN),
        .resetHigh(resetHigh));
    swr_proc_model proc (.sys_clk(sys_clk), .resetN(resetN),
        .kickEn(kickEn), .rogue(rogue), .period(period), .kick(kick));

    initial begin
        sys_clk = 1'h0;
        forever #50 sys_clk = ~sys_clk;
    end
    //////////////////////////////////////////////////////////////////////
    task automatic check(string what, logic exp, logic got);
        checksDone++;
        if (got !== exp) begin
            numErrors++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    task automatic tick();
        @(posedge sys_clk);
        #1;
        check("resetHigh", ~resetN, resetHigh);
    endtask : tick
    task automatic stay(logic val, int n);
        repeat (n) begin
            tick();
            check("resetN", val, resetN);
        end
    endtask : stay
    // edges until resetN reaches val, judged against a window
    task automatic wait_level(logic val, int lo, int hi);
        int n;
        n = 0;
        while (resetN !== val && n <= hi) begin
            tick();
            n++;
        end
        checksDone++;
        if (n < lo || n > hi) begin
            numErrors++;
            $display("MISMATCH resetN delay expected %0d..%0d seen %0d",
                lo, hi, n);
        end
    endtask : wait_level
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", checksDone, numErrors);
        if (numErrors == 0 && checksDone > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : giveVerdict
    //////////////////////////////////////////////////////////////////////
    task automatic test_powerup();
        stay(1'h0, 40);
        check("pullupEn", 1'h1, pullupEn);
        @(posedge sys_clk);
        underVoltage <= 1'h0;
        wait_level(1'h1, HOLD + 3, HOLD + 7);
        $display("test powerup done");
    endtask : test_powerup
    task automatic test_watchdog();
        kickEn <= 1'h1;
        stay(1'h1, 200);
        kickEn <= 1'h0;
        wait_level(1'h0, 1, WDT + 6);
        wait_level(1'h1, HOLD - 1, HOLD + 3);
        wait_level(1'h0, WDT - 2, WDT + 2);
        // toggle faster than the hold so kicks really land inside it
        rogue <= 1'h1;
        period <= 8'h04;
        wait_level(1'h1, HOLD - 1, HOLD + 3);
        rogue <= 1'h0;
        wait_level(1'h0, WDT - 2, WDT + 6);
        kickEn <= 1'h1;
        wait_level(1'h1, HOLD - 1, HOLD + 3);
        $display("test watchdog done");
    endtask : test_watchdog
    task automatic test_manual();
        @(posedge sys_clk);
        manualResetInputN <= 1'h0;
        wait_level(1'h0, 3, 5);
        stay(1'h0, 40);
        @(posedge sys_clk);
        manualResetInputN <= 1'h1;
        wait_level(1'h1, HOLD + 3, HOLD + 7);
        $display("test manual done");
    endtask : test_manual
    task automatic test_dips();
        @(posedge sys_clk);
        underVoltage <= 1'h1;
        wait_level(1'h0, 3, 5);
        // each good gap is shorter than the hold, so no release between
        repeat (5) begin
            @(posedge sys_clk);
            underVoltage <= 1'h0;
            stay(1'h0, 12);
            @(posedge sys_clk);
            underVoltage <= 1'h1;
            stay(1'h0, 6);
        end
        @(posedge sys_clk);
        underVoltage <= 1'h0;
        wait_level(1'h1, HOLD + 3, HOLD + 7);
        $display("test dips done");
    endtask : test_dips
    //////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            numErrors++;
            giveVerdict();
        end
    end
    initial begin
        numErrors = 0;
        checksDone = 0;
        cycles = 0;
        reset_n = 1'h0;
        underVoltage = 1'h1;
        manualResetInputN = 1'h1;
        kickEn = 1'h0;
        rogue = 1'h0;
        period = 8'h1e;
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'h1;
        test_powerup();
        test_watchdog();
        period <= 8'h03;
        test_manual();
        test_dips();
        giveVerdict();
    end
endmodule : testbench

`default_nettype wire
